/* File: pkg/hrcr_pkg.sv */
// constants and types of the humidity result and configuration registers
// assumes a single 40 MHz clock domain and a 16-bit register word
package hrcr_pkg;

    // register pointer values
    localparam logic [7:0]  PTR_TEMP     = 8'h00;
    localparam logic [7:0]  PTR_HUM      = 8'h01;
    localparam logic [7:0]  PTR_CFG      = 8'h02;

    // values after reset
    localparam logic [7:0]  PTR_RESET    = 8'h00;
    localparam logic [15:0] CFG_RESET    = 16'h1000;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    // configuration field positions
    localparam int          CFG_SWRST    = 15;
    localparam int          CFG_RSVD     = 14;
    localparam int          CFG_HEAT     = 13;
    localparam int          CFG_MODE     = 12;
    localparam int          CFG_BATT     = 11;
    localparam int          CFG_TRES     = 10;
    localparam int          CFG_HRES_HI  = 9;
    localparam int          CFG_HRES_LO  = 8;

    // result layout: 14-bit code left aligned in 16 bits
    localparam int          CODE_W       = 14;
    localparam int          RESULT_LSB   = 2;
    localparam logic [1:0]  RESULT_PAD   = 2'h0;
    localparam logic [7:0]  CFG_LOW_PAD  = 8'h00;

    // scaling: percent = word / 2**16 * 100
    localparam int          SCALE_BITS   = 16;
    localparam int          FULL_SCALE   = 100;

    // acquisition sequencer states
    typedef enum logic [1:0]
    {
        ACQ_IDLE = 2'b00,
        ACQ_TEMP = 2'b01,
        ACQ_HUM  = 2'b11
    } hrcr_state_e;

endpackage

/* File: pkg/hrcr_acq_if.sv */
// signals between register front end and acquisition sequencer
// assumes both ends share clk and rst
`timescale 1ns/1ps
interface hrcr_acq_if
(
    input wire logic clk,
    input wire logic rst
);
    logic        start;
    logic        start_hum;
    logic        seq;
    logic        clr;
    logic        t_res;
    logic [1:0]  h_res;
    logic [15:0] temp_word;
    logic [15:0] hum_word;
    logic        temp_rdy;
    logic        hum_rdy;
    logic        done;

    modport ctl
    (
        input  clk, rst, temp_word, hum_word, temp_rdy, hum_rdy, done,
        output start, start_hum, seq, clr, t_res, h_res
    );
    modport eng
    (
        input  clk, rst, start, start_hum, seq, clr, t_res, h_res,
        output temp_word, hum_word, temp_rdy, hum_rdy, done
    );
endinterface

/* File: hdl/hrcr_acq_engine.sv */
// acquisition sequencer driving the analog front end, holds results
// assumes one conv_done pulse per conv_start unless aborted
`timescale 1ns/1ps
module hrcr_acq_engine
(
    // towards the register front end
    hrcr_acq_if.eng           acq,
    // analog front end
    output logic              conv_start,
    output logic              conv_hum,
    output logic [1:0]        conv_res,
    output logic              conv_abort,
    input  wire logic         conv_done,
    input  wire logic [13:0]  conv_code
);
    hrcr_pkg::hrcr_state_e state_q;
    logic                  seq_q;
    logic                  temp_end;
    logic                  hum_end;
    logic                  first_hum;

    assign temp_end  = conv_done && (state_q == hrcr_pkg::ACQ_TEMP);
    assign hum_end   = conv_done && (state_q == hrcr_pkg::ACQ_HUM);
    assign first_hum = !acq.seq && acq.start_hum;

    // sequence state
    always_ff @(posedge acq.clk)
    begin
        if (acq.rst || acq.clr)
            state_q <= hrcr_pkg::ACQ_IDLE;
        else if (acq.start)
            state_q <= first_hum ? hrcr_pkg::ACQ_HUM
                                 : hrcr_pkg::ACQ_TEMP;
        else if (conv_done)
        begin
            unique case (state_q)
                hrcr_pkg::ACQ_IDLE: state_q <= hrcr_pkg::ACQ_IDLE;
                hrcr_pkg::ACQ_TEMP: state_q <= seq_q ? hrcr_pkg::ACQ_HUM
                                                     : hrcr_pkg::ACQ_IDLE;
                hrcr_pkg::ACQ_HUM:  state_q <= hrcr_pkg::ACQ_IDLE;
                default:            state_q <= hrcr_pkg::ACQ_IDLE;
            endcase
        end
    end

    // mode latched per trigger
    always_ff @(posedge acq.clk)
    begin
        if (acq.rst)
            seq_q <= 1'b0;
        else if (acq.start)
            seq_q <= acq.seq;
    end

    // front end commands
    always_ff @(posedge acq.clk)
    begin
        if (acq.rst)
        begin
            conv_start <= 1'b0;
            conv_hum   <= 1'b0;
            conv_res   <= 2'h0;
            conv_abort <= 1'b0;
        end
        else
        begin
            conv_start <= (acq.start && !acq.clr) || (temp_end && seq_q);
            conv_abort <= (acq.start || acq.clr)
                          && (state_q != hrcr_pkg::ACQ_IDLE);
            if (acq.start)
            begin
                conv_hum <= first_hum;
                conv_res <= first_hum ? acq.h_res : {1'b0, acq.t_res};
            end
            else if (temp_end && seq_q)
            begin
                conv_hum <= 1'b1;
                conv_res <= acq.h_res;
            end
        end
    end

    // results, always 14 bits left aligned
    always_ff @(posedge acq.clk)
    begin
        if (acq.rst || acq.clr)
        begin
            acq.temp_word <= hrcr_pkg::RESULT_RESET;
            acq.hum_word  <= hrcr_pkg::RESULT_RESET;
        end
        else
        begin
            if (temp_end)
                acq.temp_word <= {conv_code, hrcr_pkg::RESULT_PAD};
            if (hum_end)
                acq.hum_word  <= {conv_code, hrcr_pkg::RESULT_PAD};
        end
    end

    // availability flags, completion wins over a clearing trigger
    always_ff @(posedge acq.clk)
    begin
        if (acq.rst)
        begin
            acq.temp_rdy <= 1'b0;
            acq.hum_rdy  <= 1'b0;
            acq.done     <= 1'b0;
        end
        else
        begin
            acq.temp_rdy <= temp_end || (acq.temp_rdy && !acq.start
                                         && !acq.clr);
            acq.hum_rdy  <= hum_end || (acq.hum_rdy && !acq.start
                                        && !acq.clr);
            acq.done     <= hum_end || (temp_end && !seq_q);
        end
    end

endmodule

/* File: hdl/hrcr_regs.sv */
// humidity result and configuration/status registers behind the pointer
// assumes serial framing outside delivers pointer bytes and 16-bit words
`timescale 1ns/1ps
// Function
// - humidity result is a 16-bit unsigned binary register
// - two lowest result bits always read zero
// - every humidity result is 14 bits, left aligned
// - percent humidity equals register value over 2^16 times 100
// - humidity field is read-only; writes leave it unchanged
// - pointer value one selects the humidity result
// - pointer value two selects configuration and status
// - writing one to bit 15 starts software reset; bit reads zero
// - mode zero: a trigger acquires temperature or humidity only
// - mode one: a trigger acquires temperature then humidity
// - bit 11 reads one when supply below 2.8 V; writes ignored
// - bit 10 picks temperature resolution: 0 is 14, 1 is 11 bits
// - bits 9:8 pick humidity resolution: 00 14, 01 11, 10 8 bits
// - reading a result not yet available is answered with a NACK
module hrcr_regs
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // pointer byte received after a write address
    input  wire logic         ptr_wr,
    input  wire logic [7:0]   ptr_byte,
    output logic              ptr_ack,
    // data word received after the pointer
    input  wire logic         wr_stb,
    input  wire logic [15:0]  wr_data,
    output logic              wr_ack,
    // read of the word at the pointer
    input  wire logic         rd_stb,
    output logic              rd_done,
    output logic              rd_ack,
    output logic [15:0]       rd_data,
    // analog front end
    output logic              conv_start,
    output logic              conv_hum,
    output logic [1:0]        conv_res,
    output logic              conv_abort,
    input  wire logic         conv_done,
    input  wire logic [13:0]  conv_code,
    // status and control lines
    input  wire logic         batt_low,
    output logic              heater_en,
    output logic              drdy_n
);
    logic [7:0]   ptr_q;
    logic         heater_q;
    logic         mode_q;
    logic         tres_q;
    logic [1:0]   hres_q;
    logic         drdy_n_q;
    logic         rd_done_q;
    logic         rd_ack_q;
    logic [15:0]  rd_data_q;
    logic         ptr_known;
    logic         trigger;
    logic         cfg_wr;
    logic         sw_reset;
    logic [15:0]  cfg_view;
    logic         rd_ok_d;
    logic [15:0]  rd_data_d;

    hrcr_acq_if acq_bus
    (
        .clk (clk),
        .rst (rst)
    );

    hrcr_acq_engine u_engine
    (
        .acq        (acq_bus),
        .conv_start (conv_start),
        .conv_hum   (conv_hum),
        .conv_res   (conv_res),
        .conv_abort (conv_abort),
        .conv_done  (conv_done),
        .conv_code  (conv_code)
    );

    // pointer decode
    assign ptr_known = (ptr_byte == hrcr_pkg::PTR_TEMP)
                    || (ptr_byte == hrcr_pkg::PTR_HUM)
                    || (ptr_byte == hrcr_pkg::PTR_CFG);
    assign ptr_ack   = ptr_wr && ptr_known;
    assign trigger   = ptr_wr && ((ptr_byte == hrcr_pkg::PTR_TEMP)
                               || (ptr_byte == hrcr_pkg::PTR_HUM));

    // only the configuration word accepts data
    assign cfg_wr    = wr_stb && (ptr_q == hrcr_pkg::PTR_CFG);
    assign wr_ack    = cfg_wr;
    assign sw_reset  = cfg_wr && wr_data[hrcr_pkg::CFG_SWRST];

    // towards the sequencer
    assign acq_bus.start     = trigger && !sw_reset;
    assign acq_bus.start_hum = (ptr_byte == hrcr_pkg::PTR_HUM);
    assign acq_bus.seq       = mode_q;
    assign acq_bus.clr       = sw_reset;
    assign acq_bus.t_res     = tres_q;
    assign acq_bus.h_res     = hres_q;

    // pointer register, kept across reads
    always_ff @(posedge clk)
    begin
        if (rst)
            ptr_q <= hrcr_pkg::PTR_RESET;
        else if (ptr_wr)
            ptr_q <= ptr_byte;
    end

    // configuration fields
    always_ff @(posedge clk)
    begin
        if (rst || sw_reset)
        begin
            heater_q <= hrcr_pkg::CFG_RESET[hrcr_pkg::CFG_HEAT];
            mode_q   <= hrcr_pkg::CFG_RESET[hrcr_pkg::CFG_MODE];
            tres_q   <= hrcr_pkg::CFG_RESET[hrcr_pkg::CFG_TRES];
            hres_q   <= hrcr_pkg::CFG_RESET[hrcr_pkg::CFG_HRES_HI:
                                            hrcr_pkg::CFG_HRES_LO];
        end
        else if (cfg_wr)
        begin
            heater_q <= wr_data[hrcr_pkg::CFG_HEAT];
            mode_q   <= wr_data[hrcr_pkg::CFG_MODE];
            tres_q   <= wr_data[hrcr_pkg::CFG_TRES];
            hres_q   <= wr_data[hrcr_pkg::CFG_HRES_HI:
                                hrcr_pkg::CFG_HRES_LO];
        end
    end

    // configuration readback: reset bit and reserved bits read zero
    always_comb
    begin
        cfg_view                        = hrcr_pkg::RESULT_RESET;
        cfg_view[hrcr_pkg::CFG_SWRST]   = 1'b0;
        cfg_view[hrcr_pkg::CFG_RSVD]    = 1'b0;
        cfg_view[hrcr_pkg::CFG_HEAT]    = heater_q;
        cfg_view[hrcr_pkg::CFG_MODE]    = mode_q;
        cfg_view[hrcr_pkg::CFG_BATT]    = batt_low;
        cfg_view[hrcr_pkg::CFG_TRES]    = tres_q;
        cfg_view[hrcr_pkg::CFG_HRES_HI:hrcr_pkg::CFG_HRES_LO] = hres_q;
        cfg_view[hrcr_pkg::CFG_HRES_LO-1:0] = hrcr_pkg::CFG_LOW_PAD;
    end

    // read select and availability
    always_comb
    begin
        rd_ok_d   = 1'b0;
        rd_data_d = hrcr_pkg::RESULT_RESET;
        unique case (ptr_q)
            hrcr_pkg::PTR_TEMP:
            begin
                rd_ok_d   = acq_bus.temp_rdy;
                rd_data_d = acq_bus.temp_word;
            end
            hrcr_pkg::PTR_HUM:
            begin
                rd_ok_d   = acq_bus.hum_rdy;
                rd_data_d = acq_bus.hum_word;
            end
            hrcr_pkg::PTR_CFG:
            begin
                rd_ok_d   = 1'b1;
                rd_data_d = cfg_view;
            end
            default:
            begin
                rd_ok_d   = 1'b0;
                rd_data_d = hrcr_pkg::RESULT_RESET;
            end
        endcase
    end

    // read answer, one cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rd_done_q <= 1'b0;
            rd_ack_q  <= 1'b0;
            rd_data_q <= hrcr_pkg::RESULT_RESET;
        end
        else
        begin
            rd_done_q <= rd_stb;
            if (rd_stb)
            begin
                rd_ack_q  <= rd_ok_d;
                rd_data_q <= rd_ok_d ? rd_data_d : hrcr_pkg::RESULT_RESET;
            end
        end
    end

    // data ready line: low from completion to next trigger or software reset
    always_ff @(posedge clk)
    begin
        if (rst || sw_reset)
            drdy_n_q <= 1'b1;
        else if (acq_bus.done)
            drdy_n_q <= 1'b0;
        else if (acq_bus.start)
            drdy_n_q <= 1'b1;
    end

    assign rd_done   = rd_done_q;
    assign rd_ack    = rd_ack_q;
    assign rd_data   = rd_data_q;
    assign heater_en = heater_q;
    assign drdy_n    = drdy_n_q;

endmodule

/* File: dv/hrcr_fe_model.sv */
// behavioural analog front end answering conversion requests
// assumes the testbench sets latency and code between conversions
`timescale 1ns/1ps
module hrcr_fe_model
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // requests from the block
    input  wire logic        conv_start,
    input  wire logic        conv_hum,
    input  wire logic [1:0]  conv_res,
    input  wire logic        conv_abort,
    output logic             conv_done,
    output logic [13:0]      conv_code,
    // testbench control and history
    input  wire logic [7:0]  lat,
    input  wire logic [13:0] code,
    output logic [1:0]       hist,
    output logic [1:0]       res_q
);
    logic       busy_q;
    logic [7:0] cnt_q;

    // code valid only with done, inverted otherwise
    assign conv_code = conv_done ? code : ~code;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            busy_q    <= 1'b0;
            conv_done <= 1'b0;
            cnt_q     <= 8'h00;
            hist      <= 2'h0;
            res_q     <= 2'h0;
        end
        else
        begin
            conv_done <= 1'b0;
            if (conv_start)
            begin
                busy_q <= 1'b1;
                cnt_q  <= lat;
                hist   <= {hist[0], conv_hum};
                res_q  <= conv_res;
            end
            else if (conv_abort)
                busy_q <= 1'b0;
            else if (busy_q && cnt_q == 8'h00)
            begin
                busy_q    <= 1'b0;
                conv_done <= 1'b1;
            end
            else if (busy_q)
                cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule

/* File: dv/hrcr_chk.sv */
// port checker for the register block
// assumes single clock, synchronous active high reset
`timescale 1ns/1ps
module hrcr_chk
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ptr_wr,
    input wire logic [7:0]  ptr_byte,
    input wire logic        ptr_ack,
    input wire logic        wr_stb,
    input wire logic [15:0] wr_data,
    input wire logic        wr_ack,
    input wire logic        rd_stb,
    input wire logic        rd_done,
    input wire logic        rd_ack,
    input wire logic [15:0] rd_data,
    input wire logic        conv_hum,
    input wire logic        conv_start,
    input wire logic        conv_abort,
    input wire logic        conv_done,
    input wire logic        batt_low,
    input wire logic        heater_en,
    input wire logic        drdy_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] ptr_q;
    logic       busy_q;

    // front end conversion in flight
    always_ff @(posedge clk)
    begin
        if (rst)
            busy_q <= 1'b0;
        else if (conv_start)
            busy_q <= 1'b1;
        else if (conv_done || conv_abort)
            busy_q <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            ptr_q <= 8'h00;
        else if (ptr_wr)
            ptr_q <= ptr_byte;
    end

    property p_rd; rd_stb |=> rd_done; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_pad; rd_done |-> rd_data[1:0] == 2'h0; endproperty
    a_pad: assert property (p_pad) else $error("low bits set");
    property p_nack; rd_done && !rd_ack |-> rd_data == 16'h0000; endproperty
    a_nack: assert property (p_nack) else $error("nack data");
    property p_ptr; ptr_wr |-> ptr_ack == (ptr_byte < 8'h03); endproperty
    a_ptr: assert property (p_ptr) else $error("pointer ack");
    property p_wr; wr_stb |-> wr_ack == (ptr_q == 8'h02); endproperty
    a_wr: assert property (p_wr) else $error("write ack");
    property p_heat;
        wr_stb && wr_ack |=>
            heater_en == ($past(wr_data[13]) && !$past(wr_data[15]));
    endproperty
    a_heat: assert property (p_heat) else $error("heater");
    property p_cfg;
        rd_stb && ptr_q == 8'h02 |=> rd_ack && rd_data[15:14] == 2'h0
            && rd_data[7:0] == 8'h00 && rd_data[11] == $past(batt_low);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config read");
    property p_swrst;
        wr_stb && wr_ack && wr_data[15] |=> drdy_n && !heater_en;
    endproperty
    a_swrst: assert property (p_swrst) else $error("soft reset");
    property p_abort;
        wr_stb && wr_ack && wr_data[15] && busy_q |=> conv_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort");
    property p_drdy; conv_done && conv_hum |-> ##2 !drdy_n; endproperty
    a_drdy: assert property (p_drdy) else $error("ready flag");

    c_nack: cover property (rd_done && !rd_ack);
    c_hum: cover property (conv_done && conv_hum);
    c_swrst: cover property (wr_stb && wr_ack && wr_data[15]);
endmodule

bind hrcr_regs hrcr_chk hrcr_chk_inst
(
    .clk, .rst, .ptr_wr, .ptr_byte, .ptr_ack, .wr_stb, .wr_data, .wr_ack,
    .rd_stb, .rd_done, .rd_ack, .rd_data, .conv_hum, .conv_start,
    .conv_abort, .conv_done,
    .batt_low, .heater_en, .drdy_n
);

/* File: dv/testbench.sv */
// self-checking bench for the register block and front end model
// assumes reads answer one cycle after the strobe
`timescale 1ns/1ps
module testbench;
    logic        clk = 0, rst = 1, ptr_wr = 0, wr_stb = 0, rd_stb = 0;
    logic        batt_low = 0;
    logic [7:0]  ptr_byte = 8'h00, lat = 8'h04;
    logic [15:0] wr_data = 16'h0000, rd_data;
    logic        ptr_ack, wr_ack, rd_done, rd_ack, heater_en, drdy_n;
    logic        conv_start, conv_hum, conv_abort, conv_done;
    logic [1:0]  conv_res, hist, res_q;
    logic [13:0] conv_code, code = 14'h0000;
    int          error_cnt = 0, n_tests = 0;
    logic [16:0] q[$];

    always #12.5 clk = ~clk;

    hrcr_regs hrcr_regs_inst (.clk, .rst, .ptr_wr, .ptr_byte, .ptr_ack,
        .wr_stb, .wr_data, .wr_ack, .rd_stb, .rd_done, .rd_ack, .rd_data,
        .conv_start, .conv_hum, .conv_res, .conv_abort, .conv_done,
        .conv_code, .batt_low, .heater_en, .drdy_n);
    hrcr_fe_model hrcr_fe_model_inst (.clk, .rst, .conv_start, .conv_hum,
        .conv_res, .conv_abort, .conv_done, .conv_code, .lat, .code,
        .hist, .res_q);

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task wrap_up;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // pointer byte (k=0) or data word (k=1) with expected ack
    task xf(input bit k, input logic [15:0] v, input logic a);
        @(negedge clk);
        if (k)
        begin
            wr_stb = 1;
            wr_data = v;
        end
        else
        begin
            ptr_wr = 1;
            ptr_byte = v[7:0];
        end
        #1 chk({16'h0000, k ? wr_ack : ptr_ack}, {16'h0000, a});
        @(negedge clk);
        wr_stb = 0;
        ptr_wr = 0;
    endtask

    task rd(input logic [16:0] e);
        q.push_back(e);
        @(negedge clk) rd_stb = 1;
        @(negedge clk) rd_stb = 0;
    endtask

    task wait_rdy;
        for (int i = 0; i < 400 && drdy_n !== 1'b0; i++)
            @(negedge clk);
        if (drdy_n !== 1'b0)
        begin
            error_cnt++;
            $display("[FAIL] %0t no ready", $time);
            wrap_up;
        end
    endtask

    always @(negedge clk)
    begin
        if (rd_done === 1'b1 && q.size() == 0)
        begin
            error_cnt++;
            $display("[FAIL] %0t unexpected read", $time);
        end
        else if (rd_done === 1'b1)
            chk({rd_ack, rd_data}, q.pop_front());
    end

    initial
    begin
        void'($urandom(32'hB199));
        repeat (16) @(negedge clk);
        rst = 0;
        rd(17'h00000);
        xf(0, 16'h0002, 1);
        rd({1'b1, 16'h1000});
        batt_low = 1;
        rd({1'b1, 16'h1800});
        batt_low = 0;
        xf(1, 16'h3F00, 1);
        chk({16'h0000, heater_en}, 17'h00001);
        rd({1'b1, 16'h3700});
        for (int i = 0; i < 4; i++)
        begin
            code = 14'($urandom);
            lat = 8'($urandom_range(2, 30));
            xf(0, 16'h0002, 1);
            xf(1, {6'h08, i[1:0], 8'h00}, 1);
            xf(0, 16'h0001, 1);
            wait_rdy;
            chk({14'h0000, hist[0], res_q}, {14'h0000, 1'b1, i[1:0]});
            rd({1'b1, code, 2'h0});
            xf(1, 16'hFFFF, 0);
            rd({1'b1, code, 2'h0});
        end
        xf(0, 16'h0000, 1);
        wait_rdy;
        chk({13'h0000, hist, res_q}, {13'h0000, 2'h2, 2'h0});
        rd({1'b1, code, 2'h0});
        xf(0, 16'h0002, 1);
        xf(1, 16'h1000, 1);
        xf(0, 16'h0001, 1);
        wait_rdy;
        chk({15'h0000, hist}, {15'h0000, 2'h1});
        rd({1'b1, code, 2'h0});
        lat = 8'hC8;
        xf(0, 16'h0001, 1);
        rd(17'h00000);
        xf(0, 16'h0002, 1);
        xf(1, 16'hA000, 1);
        rd({1'b1, 16'h1000});
        chk({16'h0000, heater_en}, 17'h00000);
        xf(0, 16'h0003, 0);
        rd(17'h00000);
        repeat (4) @(negedge clk);
        wrap_up;
    end
endmodule
